// File: common/flash_seq_pkg.sv
/*
  Shared constants and carriers for the flash self-programming sequencer.
  Assumes one 25 MHz system clock and an oscillator tick synchronous to it.
*/
package flash_seq_pkg;

  // Array geometry, in instruction words and bytes
  localparam int ROW_WORDS = 64;
  localparam int PAGE_ROWS = 8;
  localparam int PAGE_WORDS = 512;
  localparam int BYTES_PER_WORD = 3;
  localparam int ROW_BYTES = 192;
  localparam int PAGE_BYTES = 1536;
  localparam int ROW_SHIFT = 6;
  localparam int PAGE_SHIFT = 9;

  // Word and address widths
  localparam int WORD_W = 24;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 6;

  // Table write length in clock cycles
  localparam int TW_CYCLES = 2;

  // Control register layout and reset value
  localparam int START_BIT = 15;
  localparam int OP_LSB = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WORD = 2'h1;
  localparam logic [1:0] OP_ROW = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // Unlock key sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Operation lengths in oscillator ticks
  localparam int ROW_OSC_TICKS = 11064;
  localparam int ERASE_OSC_TICKS = 20000;
  localparam int WORD_OSC_TICKS = 400;
  localparam int TICK_W = 16;

  typedef struct packed {
    logic high;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } tw_req_t;

  typedef struct packed {
    logic prog;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } flash_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_TIME = 3'b100
  } seq_state_t;

endpackage

// File: src/row_buffer.sv
/*
  Holding buffer for one flash row, written by halves, read through a register.
  Assumes one writer and one reader on the same clock.
*/
module row_buffer #(
  parameter int DEPTH = flash_seq_pkg::ROW_WORDS,
  parameter int AW = flash_seq_pkg::IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Write side
  input wire logic lo_we,
  input wire logic hi_we,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [15:0] wr_lo,
  input wire logic [7:0] wr_hi,
  // Read side
  input wire logic [AW-1:0] rd_idx,
  output logic [23:0] rd_data_q
);
  import flash_seq_pkg::*;

  logic [15:0] lo_mem [DEPTH];
  logic [7:0] hi_mem [DEPTH];

  // No reset on the arrays: contents are don't-care until loaded
  always_ff @(posedge sys_clk) begin
    if (lo_we) begin
      lo_mem[wr_idx] <= wr_lo;
    end
    if (hi_we) begin
      hi_mem[wr_idx] <= wr_hi;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 24'h000000;
    end else begin
      rd_data_q <= {hi_mem[rd_idx], lo_mem[rd_idx]};
    end
  end

endmodule // row_buffer

// File: src/flash_self_program_seq.sv
/*
  Self-programming sequencer: holding buffer load, unlock, program/erase
  timing and core stall.
  Assumes the core issues table writes and control/key writes on plain
  strobes, and that osc_tick pulses once per fast RC oscillator period.
*/
module flash_self_program_seq
  import flash_seq_pkg::*;
#(
  parameter int ROW_TICKS = flash_seq_pkg::ROW_OSC_TICKS,
  parameter int ERASE_TICKS = flash_seq_pkg::ERASE_OSC_TICKS,
  parameter int WORD_TICKS = flash_seq_pkg::WORD_OSC_TICKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Table writes from the core
  input wire logic tw_valid,
  input wire flash_seq_pkg::tw_req_t tw_req,
  output logic tw_done,
  // Control and unlock key writes
  input wire logic ctl_we,
  input wire logic [15:0] ctl_wdata,
  input wire logic key_we,
  input wire logic [7:0] key_wdata,
  output logic [15:0] ctl_rdata,
  // Core stall
  output logic core_stall,
  // Oscillator timebase
  input wire logic osc_tick,
  // Flash array command
  output flash_seq_pkg::flash_cmd_t fl_cmd_q
);
  import flash_seq_pkg::*;

  function automatic logic [ADDR_W-1:0] row_base(input logic [ADDR_W-1:0] a);
    row_base = {a[ADDR_W-1:ROW_SHIFT], {ROW_SHIFT{1'b0}}};
  endfunction

  function automatic logic [ADDR_W-1:0] page_base(input logic [ADDR_W-1:0] a);
    page_base = {a[ADDR_W-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
  endfunction

  function automatic logic [TICK_W-1:0] op_ticks(input logic [1:0] op);
    if (op == OP_ROW) begin
      op_ticks = TICK_W'(ROW_TICKS);
    end else if (op == OP_ERASE) begin
      op_ticks = TICK_W'(ERASE_TICKS);
    end else begin
      op_ticks = TICK_W'(WORD_TICKS);
    end
  endfunction

  seq_state_t state_q, state_d;
  logic tw_busy_q;
  logic [ADDR_W-1:0] tgt_addr_q;
  logic key_half_q;
  logic key_ok_q;
  logic wr_bit_q;
  logic [1:0] op_q;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W:0] left_q;
  logic out_q;
  logic [IDX_W-1:0] out_idx_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [23:0] buf_rd_data;

  // Table write acceptance: refused while an operation runs
  wire idle = (state_q == ST_IDLE);
  wire tw_accept = tw_valid & ~tw_busy_q & idle;
  wire buf_lo_we = tw_accept & ~tw_req.high;
  wire buf_hi_we = tw_accept & tw_req.high;
  // Buffer slot is the low address bits; group is one aligned row
  wire [IDX_W-1:0] tw_idx = tw_req.addr[IDX_W-1:0];

  // Start decode
  wire [1:0] ctl_op = ctl_wdata[OP_LSB +: 2];
  wire start_req = ctl_we & ctl_wdata[START_BIT] & idle;
  wire start_go = start_req & key_ok_q & (ctl_op != OP_NONE);
  wire [IDX_W:0] push_len = (ctl_op == OP_ROW) ? (IDX_W+1)'(ROW_WORDS) : (IDX_W+1)'(1);
  wire [IDX_W-1:0] push_first = (ctl_op == OP_ROW) ? '0 : tgt_addr_q[IDX_W-1:0];

  // Push and timing progress
  wire push_done = (state_q == ST_PUSH) & (left_q == '0) & ~out_q;
  wire tick_last = osc_tick & (tick_cnt_q == op_ticks(op_q) - TICK_W'(1));
  wire op_done = (state_q == ST_TIME) & tick_last;

  // Two-cycle table write: taken in cycle 0, done in cycle 1
  assign tw_done = tw_busy_q;
  // Core held for the whole erase or program
  assign core_stall = ~idle;
  assign ctl_rdata = {wr_bit_q, 13'h0000, op_q};

  row_buffer #(
    .DEPTH(ROW_WORDS),
    .AW(IDX_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .lo_we(buf_lo_we),
    .hi_we(buf_hi_we),
    .wr_idx(tw_idx),
    .wr_lo(tw_req.data),
    .wr_hi(tw_req.data[7:0]),
    .rd_idx(idx_q),
    .rd_data_q(buf_rd_data)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_go && ctl_op == OP_ERASE) begin
          state_d = ST_TIME;
        end else if (start_go) begin
          state_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (push_done) begin
          state_d = ST_TIME;
        end
      end
      ST_TIME: begin
        if (op_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      tw_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tw_busy_q <= tw_accept;
    end
  end

  // Last table write address selects row, word and page
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tgt_addr_q <= '0;
    end else if (tw_accept) begin
      tgt_addr_q <= tw_req.addr;
    end
  end

  // Key is KEY_FIRST then KEY_SECOND, idle cycles allowed between; a control write or accepted table write breaks it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      key_half_q <= 1'b0;
      key_ok_q <= 1'b0;
    end else if (key_we) begin
      key_half_q <= (key_wdata == KEY_FIRST);
      key_ok_q <= key_half_q & (key_wdata == KEY_SECOND);
    end else if (ctl_we || tw_accept) begin
      key_half_q <= 1'b0;
      key_ok_q <= 1'b0;
    end
  end

  // Start bit and op field; writes while busy are ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_bit_q <= CTL_RESET[START_BIT];
      op_q <= CTL_RESET[OP_LSB +: 2];
    end else if (op_done) begin
      wr_bit_q <= 1'b0;
    end else if (ctl_we && idle) begin
      wr_bit_q <= start_go;
      op_q <= ctl_op;
    end
  end

  // Buffer drain: one read per cycle, data one cycle later
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= '0;
      left_q <= '0;
      out_q <= 1'b0;
      out_idx_q <= '0;
    end else if (start_go) begin
      idx_q <= push_first;
      left_q <= push_len;
      out_q <= 1'b0;
    end else if (state_q == ST_PUSH && left_q != '0) begin
      idx_q <= idx_q + IDX_W'(1);
      left_q <= left_q - (IDX_W+1)'(1);
      out_q <= 1'b1;
      out_idx_q <= idx_q;
    end else begin
      out_q <= 1'b0;
    end
  end

  // Oscillator tick count for the active operation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= '0;
    end else if (state_q != ST_TIME) begin
      tick_cnt_q <= '0;
    end else if (osc_tick) begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // Array commands: row-aligned word writes or a page-aligned erase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fl_cmd_q <= '0;
    end else begin
      fl_cmd_q.prog <= out_q;
      fl_cmd_q.erase <= start_go & (ctl_op == OP_ERASE);
      fl_cmd_q.data <= buf_rd_data;
      if (start_go && ctl_op == OP_ERASE) begin
        fl_cmd_q.addr <= page_base(tgt_addr_q);
      end else if (out_q) begin
        fl_cmd_q.addr <= row_base(tgt_addr_q) | ADDR_W'(out_idx_q);
      end
    end
  end

endmodule // flash_self_program_seq

// File: sim/flash_seq_monitor.sv
/*
  Port checker for the flash self-programming sequencer.
  Assumes one clock domain and the bind below this module.
*/
module flash_seq_monitor
  import flash_seq_pkg::*;
#(
  parameter int ROW_TICKS = 8,
  parameter int ERASE_TICKS = 12,
  parameter int WORD_TICKS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic tw_valid,
  input wire flash_seq_pkg::tw_req_t tw_req,
  input wire logic tw_done,
  input wire logic ctl_we,
  input wire logic [15:0] ctl_wdata,
  input wire logic key_we,
  input wire logic [7:0] key_wdata,
  input wire logic [15:0] ctl_rdata,
  input wire logic core_stall,
  input wire logic osc_tick,
  input wire flash_seq_pkg::flash_cmd_t fl_cmd_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence key_pair;
    key_we && key_wdata == KEY_FIRST ##1 key_we && key_wdata == KEY_SECOND;
  endsequence
  sequence start_req;
    ctl_we && ctl_wdata[START_BIT] && ctl_wdata[1:0] != OP_NONE && !core_stall;
  endsequence
  a_done_pulse: assert property (tw_done |=> !tw_done)
    else $error("done too long");
  a_done_take: assert property (tw_valid && !tw_done && !core_stall |=> tw_done)
    else $error("write not answered");
  a_done_cause: assert property (tw_done |-> $past(tw_valid))
    else $error("stray done");
  a_stall_flag: assert property (core_stall == ctl_rdata[START_BIT])
    else $error("start flag and stall differ");
  a_start_stall: assert property (key_pair ##1 start_req |=> core_stall)
    else $error("unlocked start ignored");
  a_rekey_refuse: assert property ((ctl_we && !core_stall) ##1 start_req |=> !core_stall)
    else $error("start without key");
  a_stall_bound: assert property ($rose(core_stall) |-> ##[1:1000] !core_stall)
    else $error("stall never ends");
  a_cmd_in_op: assert property (fl_cmd_q.prog || fl_cmd_q.erase |-> core_stall)
    else $error("command outside operation");
  a_row_step: assert property (fl_cmd_q.prog && $past(fl_cmd_q.prog)
    |-> fl_cmd_q.addr == $past(fl_cmd_q.addr) + 16'h0001) else $error("row address skip");
  a_page_align: assert property (fl_cmd_q.erase |-> fl_cmd_q.addr[8:0] == 9'h000)
    else $error("erase not page aligned");
endmodule // flash_seq_monitor
bind flash_self_program_seq flash_seq_monitor #(.ROW_TICKS(ROW_TICKS),
  .ERASE_TICKS(ERASE_TICKS), .WORD_TICKS(WORD_TICKS)) u_mon (.sys_clk, .rstn,
  .tw_valid, .tw_req, .tw_done, .ctl_we, .ctl_wdata, .key_we, .key_wdata,
  .ctl_rdata, .core_stall, .osc_tick, .fl_cmd_q);

// File: sim/core_model.sv
/*
  Core model issuing table writes into the holding buffer.
  Assumes callers run just after a rising clock edge.
*/
module core_model
  import flash_seq_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Table write handshake
  output logic tw_valid,
  output flash_seq_pkg::tw_req_t tw_req,
  input wire logic tw_done
);
  initial begin
    tw_valid = 1'b0;
    tw_req = '0;
  end
  // Held until done; g+1 idle cycles follow, g models a slow core
  task automatic put(input logic hi, input logic [15:0] a, input logic [15:0] d,
    input int g, output int n);
    tw_valid = 1'b1;
    tw_req = '{hi, a, d};
    n = 0;
    // Held through the edge that samples done, then released
    do begin
      @(posedge sys_clk);
      n++;
    end while (tw_done !== 1'b1 && n < 50);
    #1;
    tw_valid = 1'b0;
    tw_req = ~tw_req; // Released lines never keep a stale value
    repeat (g + 1) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic load_row(input logic [15:0] base, input int g);
    int n;
    for (int i = 0; i < ROW_WORDS; i++) begin
      put(1'b0, base + 16'(i), 16'hC000 | 16'(i), g, n);
      put(1'b1, base + 16'(i), {~8'(i), 8'h5A ^ 8'(i)}, g, n);
    end
  endtask
endmodule // core_model

// File: sim/tb_flash_self_program_seq.sv
/*
  Self-checking bench for the flash sequencer.
  Assumes the core model and the bound port checker.
*/
module tb_flash_self_program_seq import flash_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, tw_valid, tw_done, ctl_we, key_we, core_stall, osc_tick, osc_en;
  tw_req_t tw_req;
  flash_cmd_t fl_cmd_q;
  logic [15:0] ctl_wdata, ctl_rdata, erase_addr;
  logic [7:0] key_wdata;
  logic [15:0] pa[$];
  logic [23:0] pd[$];
  int n_mismatch, tests_run, n_erase;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Short tick counts keep the run brief
  flash_self_program_seq #(.ROW_TICKS(8), .ERASE_TICKS(12), .WORD_TICKS(4)) u_dut (
    .sys_clk, .rstn, .tw_valid, .tw_req, .tw_done, .ctl_we, .ctl_wdata, .key_we,
    .key_wdata, .ctl_rdata, .core_stall, .osc_tick, .fl_cmd_q);
  core_model u_core (.sys_clk, .tw_valid, .tw_req, .tw_done);
  always @(posedge sys_clk) osc_tick <= #1 osc_en & ~osc_tick;
  always @(posedge sys_clk) begin
    if (fl_cmd_q.prog === 1'b1) begin
      pa.push_back(fl_cmd_q.addr);
      pd.push_back(fl_cmd_q.data);
    end
    if (fl_cmd_q.erase === 1'b1) begin
      n_erase++;
      erase_addr = fl_cmd_q.addr;
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic strobe(input logic k, input logic c, input logic [7:0] kd,
    input logic [15:0] cd);
    key_we = k;
    ctl_we = c;
    key_wdata = kd;
    ctl_wdata = cd;
    tick;
  endtask
  task automatic start(input logic [15:0] cmd);
    pa.delete();
    pd.delete();
    strobe(1'b1, 1'b0, KEY_FIRST, 16'h0000);
    strobe(1'b1, 1'b0, KEY_SECOND, 16'h0000);
    strobe(1'b0, 1'b1, 8'h00, cmd);
    strobe(1'b0, 1'b0, 8'h00, 16'h0000);
    chk(core_stall, 1'b1);
    chk(ctl_rdata, cmd);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000 && core_stall !== 1'b0; i++) tick;
    chk(core_stall, 1'b0);
  endtask
  task automatic t_refuse;
    strobe(1'b0, 1'b1, 8'h00, 16'h8002);
    strobe(1'b0, 1'b1, 8'h00, 16'h8002);
    strobe(1'b1, 1'b0, KEY_SECOND, 16'h0000);
    strobe(1'b1, 1'b0, KEY_FIRST, 16'h0000);
    strobe(1'b0, 1'b1, 8'h00, 16'h8002);
    strobe(1'b0, 1'b0, 8'h00, 16'h0000);
    chk(core_stall, 1'b0);
    chk(ctl_rdata, 16'h0002);
    // Unlocked start with no operation selected
    strobe(1'b1, 1'b0, KEY_FIRST, 16'h0000);
    strobe(1'b1, 1'b0, KEY_SECOND, 16'h0000);
    strobe(1'b0, 1'b1, 8'h00, 16'h8000);
    strobe(1'b0, 1'b0, 8'h00, 16'h0000);
    chk(core_stall, 1'b0);
    chk(ctl_rdata, 16'h0000);
  endtask
  task automatic t_row;
    int n;
    u_core.put(1'b0, 16'h00C0, 16'h0000, 0, n);
    chk(n, 2);
    u_core.load_row(16'h00C0, 0);
    start(16'h8002);
    strobe(1'b0, 1'b1, 8'h00, 16'h0000);
    strobe(1'b0, 1'b0, 8'h00, 16'h0000);
    chk(ctl_rdata, 16'h8002);
    wait_idle;
    chk(ctl_rdata, 16'h0002);
    chk(pa.size(), ROW_WORDS);
    for (int i = 0; i < ROW_WORDS; i++) begin
      chk(pa[i], 16'h00C0 + 16'(i));
      chk(pd[i], {8'h5A ^ 8'(i), 16'hC000 | 16'(i)});
    end
  endtask
  task automatic t_word;
    int n;
    u_core.put(1'b0, 16'h0123, 16'h1234, 3, n);
    u_core.put(1'b1, 16'h0123, 16'h009C, 3, n);
    start(16'h8001);
    wait_idle;
    chk(pa.size(), 1);
    chk({pa[0], pd[0]}, 40'h01239C1234);
  endtask
  task automatic t_erase;
    int n;
    u_core.put(1'b0, 16'h0A37, 16'hFFFF, 0, n);
    osc_en = 1'b0;
    n_erase = 0;
    start(16'h8003);
    repeat (40) tick;
    chk(core_stall, 1'b1);
    osc_en = 1'b1;
    wait_idle;
    chk(n_erase, 1);
    chk(erase_addr, 16'h0A00);
    chk(ctl_rdata, 16'h0003);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    osc_en = 1'b1;
    osc_tick = 1'b0;
    ctl_we = 1'b0;
    key_we = 1'b0;
    ctl_wdata = 16'h0000;
    key_wdata = 8'h00;
    n_mismatch = 0;
    tests_run = 0;
    n_erase = 0;
    repeat (6) tick;
    chk({tw_done, core_stall, ctl_rdata, fl_cmd_q}, 64'h0);
    rstn = 1'b1;
    t_refuse;
    t_row;
    t_word;
    t_erase;
    test_done;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    test_done;
  end
endmodule // tb_flash_self_program_seq
